// ---- rtl/catch_latch_regs.svh ----
// Register offsets, reset values and timing counts of the catch input latch.
`ifndef CATCH_LATCH_REGS_SVH
`define CATCH_LATCH_REGS_SVH
// Overview of operation
// - Catch pulses shorter than one scan
// - Six catch inputs small unit, eight otherwise
// - Four groups share one edge polarity each
// - Group one input zero, two input one
// - Group setting picks rising or falling edge
// - Flag stands for exactly the next scan
// - Capture every scan keeps flag high
// - Normal inputs sampled once at scan end
// - Hard filter preset 0 to 255 qualifies
// - Preset ten gives documented pulse widths
// - High-speed mode disables expansion and data links
// - Capacity 100 steps high-speed, 1012 standard
// - Relays 40 versus 232; catch flags kept
// - Control data registers 90 to 99 unavailable
// ******************************
// Register map
// ******************************
`define CL_OFS_CTRL 8'h00
`define CL_OFS_FILTER 8'h04
`define CL_OFS_CATCH 8'h08
`define CL_OFS_IRQ_STAT 8'h0C
`define CL_OFS_IRQ_MASK 8'h10
`define CL_OFS_LIMITS 8'h14
`define CL_CTRL_EDGE_LSB 0
`define CL_CTRL_MODE_BIT 4
`define CL_RST_FILTER 8'h0A
// ******************************
// Mode limits
// ******************************
`define CL_CAP_STD 16'h03F4
`define CL_CAP_HS 16'h0064
`define CL_RELAY_STD 16'h00E8
`define CL_RELAY_HS 16'h0028
`define CL_CTRL_DATA_FIRST 7'h5A
`define CL_CTRL_DATA_LAST 7'h63
// ******************************
// Filter timing
// ******************************
`define CL_CLK_PERIOD_NS 4
`define CL_TICK_NS 2400
`define CL_TICK_CYCLES ((`CL_TICK_NS + `CL_CLK_PERIOD_NS - 1) / `CL_CLK_PERIOD_NS)
`define CL_EXTRA_ON_FIRST 9'h002
`define CL_EXTRA_OFF_FIRST 9'h003
`define CL_EXTRA_ON_REST 9'h006
`define CL_EXTRA_OFF_REST 9'h028
`endif

// ---- rtl/catch_latch_pkg.sv ----
// Types shared by the catch input latch.
package catch_latch_pkg;
	typedef enum logic {EDGE_RISING, EDGE_FALLING} edge_t;
	typedef enum logic {PROC_STANDARD, PROC_HIGH_SPEED} proc_mode_t;
endpackage : catch_latch_pkg

// ---- rtl/tick_divider.sv ----
// One-cycle enable pulse every TICK_CYCLES clocks.
`timescale 1ns/10ps
`default_nettype none
module tick_divider #(
	parameter int TICK_CYCLES = 600
) (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic nrst,
	// Enable out
	output logic      tick
);
	logic [15:0] count;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			count <= 16'h0000;
			tick  <= 1'b0;
		end else if (count == 16'(TICK_CYCLES - 1)) begin
			count <= 16'h0000;
			tick  <= 1'b1;
		end else begin
			count <= count + 16'h0001;
			tick  <= 1'b0;
		end
	end
endmodule : tick_divider
`default_nettype wire

// ---- rtl/hard_filter.sv ----
// Hard filter of one input: a new level is taken once it has held for enough ticks.
`timescale 1ns/10ps
`default_nettype none
module hard_filter #(
	parameter logic [8:0] ON_EXTRA  = 9'h002,
	parameter logic [8:0] OFF_EXTRA = 9'h003
) (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       nrst,
	// Timing
	input  wire logic       tick,
	input  wire logic [7:0] preset,
	// Level in and out
	input  wire logic       din,
	output logic            level
);
	logic [8:0] held;
	logic [8:0] limit;

	// A rising level needs the on-pulse width, a falling one the off-pulse width.
	assign limit = {1'b0, preset} + (din ? ON_EXTRA : OFF_EXTRA);

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			held  <= 9'h000;
			level <= 1'b0;
		end else if (din == level) begin
			held <= 9'h000;
		end else if (tick) begin
			if (held >= limit) begin
				level <= din;
				held  <= 9'h000;
			end else begin
				held <= held + 9'h001;
			end
		end
	end
endmodule : hard_filter
`default_nettype wire

// ---- rtl/scan_catch_input_latch.sv ----
// Edge-capturing catch input latch with scan-synchronous flags and mode limits.
`timescale 1ns/10ps
`default_nettype none
`include "catch_latch_regs.svh"
module scan_catch_input_latch #(
	parameter int NUM_CATCH   = 8,
	parameter int TICK_CYCLES = `CL_TICK_CYCLES
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        nrst,
	// Input terminals
	input  wire logic [7:0]  inPin,
	// Scan boundary from the program sequencer
	input  wire logic        scanEnd,
	// Register port
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic [31:0]      rdata,
	// Catch flags and normal inputs
	output logic [7:0]       catchFlag,
	output logic [7:0]       normalIn,
	// Mode dependent enables and limits
	output logic             linkEnable,
	output logic             ctrlDataEnable,
	output logic [15:0]      progCapacity,
	output logic [15:0]      relayPoints,
	// Interrupt
	output logic             irq
);
	// ******************************
	// Declarations
	// ******************************
	logic [7:0]  syncA;
	logic [7:0]  syncB;
	logic [7:0]  filt;
	logic [7:0]  filtPrev;
	logic [7:0]  evt;
	logic [7:0]  pending;
	logic [3:0]  catch_edge_select;
	logic [7:0]  input_filter_setting;
	catch_latch_pkg::proc_mode_t processing_mode_select;
	logic [7:0]  irqStat;
	logic [7:0]  irqMask;
	logic [7:0]  present;
	logic        tick;
	logic        hsMode;

	assign hsMode = (processing_mode_select == catch_latch_pkg::PROC_HIGH_SPEED);

	// Group of each input: 0, 1, 2 for both 2 and 3, and 3 for four upward.
	function automatic logic [1:0] groupOf(input int idx);
		logic [1:0] g;
		g = 2'h3;
		if (idx == 0) begin
			g = 2'h0;
		end else if (idx == 1) begin
			g = 2'h1;
		end else if (idx < 4) begin
			g = 2'h2;
		end
		return g;
	endfunction : groupOf

	// ******************************
	// Filter timebase
	// ******************************
	tick_divider #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.mclk(mclk),
		.nrst(nrst),
		.tick(tick)
	);

	// ******************************
	// Per input: synchroniser, hard filter, edge detect
	// ******************************
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_in
			if (gi < NUM_CATCH) begin : g_used
				assign present[gi] = 1'b1;
				always_ff @(posedge mclk) begin
					if (!nrst) begin
						syncA[gi] <= 1'b0;
						syncB[gi] <= 1'b0;
					end else begin
						syncA[gi] <= inPin[gi];
						syncB[gi] <= syncA[gi];
					end
				end
				hard_filter #(
					.ON_EXTRA (gi == 0 ? `CL_EXTRA_ON_FIRST : `CL_EXTRA_ON_REST),
					.OFF_EXTRA(gi == 0 ? `CL_EXTRA_OFF_FIRST : `CL_EXTRA_OFF_REST)
				) u_filt (
					.mclk  (mclk),
					.nrst  (nrst),
					.tick  (tick),
					.preset(input_filter_setting),
					.din   (syncB[gi]),
					.level (filt[gi])
				);
				always_ff @(posedge mclk) begin
					if (!nrst) begin
						filtPrev[gi] <= 1'b0;
					end else begin
						filtPrev[gi] <= filt[gi];
					end
				end
				// Falling selection catches off pulses, rising catches on pulses.
				assign evt[gi] = catch_edge_select[groupOf(gi)] ?
					(filtPrev[gi] & ~filt[gi]) : (filt[gi] & ~filtPrev[gi]);
			end else begin : g_absent
				assign present[gi]  = 1'b0;
				assign syncA[gi]    = 1'b0;
				assign syncB[gi]    = 1'b0;
				assign filt[gi]     = 1'b0;
				assign filtPrev[gi] = 1'b0;
				assign evt[gi]      = 1'b0;
			end
		end
	endgenerate

	// ******************************
	// Catch capture and scan hand-over
	// ******************************
	// An edge in the boundary cycle goes straight to the next scan's flag.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			pending <= 8'h00;
		end else if (scanEnd) begin
			pending <= 8'h00;
		end else begin
			pending <= pending | evt;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			catchFlag <= 8'h00;
		end else if (scanEnd) begin
			catchFlag <= (pending | evt) & present;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			normalIn <= 8'h00;
		end else if (scanEnd) begin
			normalIn <= filt & present;
		end
	end

	// ******************************
	// Mode limits
	// ******************************
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			linkEnable     <= 1'b1;
			ctrlDataEnable <= 1'b1;
			progCapacity   <= `CL_CAP_STD;
			relayPoints    <= `CL_RELAY_STD;
		end else begin
			linkEnable     <= !hsMode;
			ctrlDataEnable <= !hsMode;
			progCapacity   <= hsMode ? `CL_CAP_HS : `CL_CAP_STD;
			relayPoints    <= hsMode ? `CL_RELAY_HS : `CL_RELAY_STD;
		end
	end

	// ******************************
	// Control registers
	// ******************************
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			catch_edge_select      <= 4'h0;
			processing_mode_select <= catch_latch_pkg::PROC_STANDARD;
		end else if (wr && addr == `CL_OFS_CTRL) begin
			catch_edge_select      <= wdata[`CL_CTRL_EDGE_LSB +: 4];
			processing_mode_select <= catch_latch_pkg::proc_mode_t'(wdata[`CL_CTRL_MODE_BIT]);
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			input_filter_setting <= `CL_RST_FILTER;
		end else if (wr && addr == `CL_OFS_FILTER) begin
			input_filter_setting <= wdata[7:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			irqMask <= 8'h00;
		end else if (wr && addr == `CL_OFS_IRQ_MASK) begin
			irqMask <= wdata[7:0];
		end
	end

	// ******************************
	// Interrupt status
	// ******************************
	// A capture in the same cycle as a write-one-to-clear keeps the bit set.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			irqStat <= 8'h00;
		end else if (wr && addr == `CL_OFS_IRQ_STAT) begin
			irqStat <= (irqStat & ~wdata[7:0]) | evt;
		end else begin
			irqStat <= irqStat | evt;
		end
	end

	assign irq = |(irqStat & irqMask);

	// ******************************
	// Read port
	// ******************************
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			rdata <= 32'h0000_0000;
		end else if (rd) begin
			unique case (addr)
				`CL_OFS_CTRL:     rdata <= {27'h0, hsMode, catch_edge_select};
				`CL_OFS_FILTER:   rdata <= {24'h0, input_filter_setting};
				`CL_OFS_CATCH:    rdata <= {16'h0, normalIn, catchFlag};
				`CL_OFS_IRQ_STAT: rdata <= {24'h0, irqStat};
				`CL_OFS_IRQ_MASK: rdata <= {24'h0, irqMask};
				`CL_OFS_LIMITS:   rdata <= {relayPoints, progCapacity};
				default:          rdata <= 32'h0000_0000;
			endcase
		end else begin
			rdata <= 32'h0000_0000;
		end
	end

	// ******************************
	// Checks
	// ******************************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	sequence s_caught0;
		!scanEnd && evt[0];
	endsequence

	sequence s_boundary;
		scanEnd && pending[0];
	endsequence

	// An edge on input zero is held until the boundary, then shows in the flag.
	a_catch_pending: assert property (s_caught0 |=> pending[0])
		else $error("catch 0 not held as pending");

	a_pending_keep: assert property (pending[0] && !scanEnd |=> pending[0])
		else $error("pending catch 0 lost inside a scan");

	a_catch_next_scan: assert property (s_boundary |=> catchFlag[0])
		else $error("catch flag 0 missing after boundary");

	a_flag_one_scan: assert property (!scanEnd |=> $stable(catchFlag))
		else $error("catch flag changed inside a scan");

	a_flag_clears: assert property (scanEnd && !(pending[0] | evt[0]) |=> !catchFlag[0])
		else $error("catch flag 0 not cleared");

	a_flag_repeat: assert property (catchFlag[0] && scanEnd && pending[0] |=> catchFlag[0])
		else $error("catch flag 0 dropped despite capture");

	a_absent_inputs: assert property ((catchFlag & ~present) == 8'h00)
		else $error("flag set on absent input");

	a_normal_sample: assert property (scanEnd |=> normalIn == ($past(filt) & present))
		else $error("normal input sample wrong");

	a_filter_write: assert property (wr && addr == `CL_OFS_FILTER |=> input_filter_setting == $past(wdata[7:0]))
		else $error("filter preset not stored");

	a_links_off: assert property (hsMode [*2] |-> !linkEnable && !ctrlDataEnable)
		else $error("link enabled in high-speed mode");

	a_capacity_mode: assert property (hsMode [*2] |-> progCapacity == `CL_CAP_HS && relayPoints == `CL_RELAY_HS)
		else $error("high-speed limits wrong");

	a_capacity_std: assert property (!hsMode [*2] |-> progCapacity == `CL_CAP_STD && ctrlDataEnable)
		else $error("standard limits wrong");

	a_group_share: assert property (
		catch_edge_select[2] && filtPrev[3] && !filt[3] && !scanEnd |=> pending[3])
		else $error("group three falling edge missed");

	a_irq_set: assert property (evt[0] && irqMask[0] && !(wr && addr == `CL_OFS_IRQ_MASK && !wdata[0]) |=> irq)
		else $error("interrupt not raised");

	a_rise_input0: assert property (!catch_edge_select[0] && !filtPrev[0] && filt[0] |-> evt[0])
		else $error("rising edge on input 0 missed");

	a_wrong_edge: assert property (!catch_edge_select[0] && filtPrev[0] && !filt[0] |-> !evt[0])
		else $error("wrong edge caught on input 0");

	a_fall_input1: assert property (catch_edge_select[1] && filtPrev[1] && !filt[1] |-> evt[1])
		else $error("falling edge on input 1 missed");

	a_group_three: assert property (catch_edge_select[2] && filtPrev[2] && !filt[2] |-> evt[2])
		else $error("group three edge on input 2 missed");

	a_group_four: assert property (catch_edge_select[3] && filtPrev[5] && !filt[5] |-> evt[5])
		else $error("group four edge on input 5 missed");

	a_four_no_rise: assert property (catch_edge_select[3] && !filtPrev[7] && filt[7] |-> !evt[7])
		else $error("group four caught a rising edge");

	a_flag_falls: assert property (catchFlag[1] && scanEnd && !(pending[1] | evt[1]) |=> !catchFlag[1])
		else $error("catch flag 1 stood longer than one scan");

	a_filter_tick: assert property (!tick |=> $stable(filt))
		else $error("filtered level moved between ticks");

	a_normal_hold: assert property (!scanEnd |=> $stable(normalIn))
		else $error("normal inputs changed inside a scan");

	a_absent_normal: assert property ((normalIn & ~present) == 8'h00)
		else $error("normal input set on absent terminal");

	a_links_std: assert property (!hsMode [*2] |-> linkEnable && relayPoints == `CL_RELAY_STD)
		else $error("standard link or relay limit wrong");

	// ******************************
	// Register port checks
	// ******************************
	a_stat_set_wins: assert property (evt[0] |=> irqStat[0])
		else $error("capture lost against status clear");

	a_stat_clear: assert property (wr && addr == `CL_OFS_IRQ_STAT && wdata[0] && !evt[0] |=> !irqStat[0])
		else $error("status bit 0 not cleared");

	a_mask_write: assert property (wr && addr == `CL_OFS_IRQ_MASK |=> irqMask == $past(wdata[7:0]))
		else $error("interrupt mask not stored");

	a_stat_read: assert property (rd && addr == `CL_OFS_IRQ_STAT |=> rdata == {24'h000000, $past(irqStat)})
		else $error("status read data wrong");

	a_rdata_idle: assert property (!rd |=> rdata == 32'h0000_0000)
		else $error("read data not zero when idle");
endmodule : scan_catch_input_latch
`default_nettype wire

// ---- tb/sensor_model.sv ----
// Sensor outputs that drive the input terminals of the catch latch.
`timescale 1ns/10ps
`default_nettype none
module sensor_model (
	// Clock
	input  wire logic  mclk,
	// Sensor outputs
	output logic [7:0] pin
);
	initial pin = 8'h00;
	// Push-pull outputs change just after a clock edge and hold for a set time.
	task automatic drive(input logic [7:0] v, input int hold);
		@(posedge mclk);
		pin <= v;
		repeat (hold) @(posedge mclk);
	endtask : drive
	// A pulse returns to the idle level and rests before the next one.
	task automatic pulse(input logic [7:0] v, input int width);
		logic [7:0] idle;
		idle = pin;
		drive(v, width);
		drive(idle, 300);
	endtask : pulse
endmodule : sensor_model
`default_nettype wire

// ---- tb/scan_catch_input_latch_test.sv ----
// Self-checking testbench of the catch input latch.
`timescale 1ns/10ps
`default_nettype none
`include "catch_latch_regs.svh"
module scan_catch_input_latch_test;
	logic        mclk = 1'b0;
	logic        nrst = 1'b0;
	logic        scanEnd = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [7:0]  inPin;
	logic [31:0] rdata;
	logic [7:0]  catchFlag;
	logic [7:0]  normalIn;
	logic        linkEnable;
	logic        ctrlDataEnable;
	logic [15:0] progCapacity;
	logic [15:0] relayPoints;
	logic        irq;
	int          error_cnt = 0;
	int          check_count = 0;
	int          cycles = 0;
	always #2 mclk = ~mclk;
	sensor_model sens (.mclk(mclk), .pin(inPin));
	scan_catch_input_latch #(.NUM_CATCH(8), .TICK_CYCLES(4)) uut (
		.mclk(mclk), .nrst(nrst), .inPin(inPin), .scanEnd(scanEnd), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .catchFlag(catchFlag), .normalIn(normalIn),
		.linkEnable(linkEnable), .ctrlDataEnable(ctrlDataEnable), .progCapacity(progCapacity),
		.relayPoints(relayPoints), .irq(irq));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask : rd_chk
	// One end-of-scan pulse; flags and normal inputs are settled afterwards.
	task automatic scan();
		@(posedge mclk);
		scanEnd <= 1'b1;
		@(posedge mclk);
		scanEnd <= 1'b0;
		#1;
	endtask : scan
	task automatic test_reset();
		chk({linkEnable, ctrlDataEnable, catchFlag, normalIn, irq}, 19'h60000);
		chk(progCapacity, `CL_CAP_STD);
		chk(relayPoints, `CL_RELAY_STD);
		rd_chk(`CL_OFS_FILTER, 32'h0000000A);
		rd_chk(8'h3C, 32'h0);
		sens.pulse(8'h01, 30);
		scan();
		chk(catchFlag, 8'h00);
		sens.pulse(8'h01, 80);
		scan();
		chk(catchFlag, 8'h01);
		$display("test_reset done");
	endtask : test_reset
	task automatic test_short_pulse();
		wr_reg(`CL_OFS_FILTER, 32'h000000FF);
		rd_chk(`CL_OFS_FILTER, 32'h000000FF);
		wr_reg(`CL_OFS_FILTER, 32'h0);
		wr_reg(`CL_OFS_CTRL, 32'h0);
		sens.pulse(8'hFF, 3);
		scan();
		chk(catchFlag, 8'h00);
		sens.pulse(8'hFF, 300);
		chk(catchFlag, 8'h00);
		scan();
		chk(catchFlag, 8'hFF);
		rd_chk(`CL_OFS_CATCH, 32'h000000FF);
		chk(irq, 1'b0);
		wr_reg(`CL_OFS_IRQ_MASK, 32'h01);
		#1 chk(irq, 1'b1);
		wr_reg(`CL_OFS_IRQ_STAT, 32'h01);
		#1 chk(irq, 1'b0);
		rd_chk(`CL_OFS_IRQ_STAT, 32'h000000FE);
		scan();
		chk(catchFlag, 8'h00);
		$display("test_short_pulse done");
	endtask : test_short_pulse
	task automatic test_groups();
		wr_reg(`CL_OFS_CTRL, 32'h0A);
		sens.drive(8'hFF, 300);
		scan();
		chk(catchFlag, 8'h0D);
		chk(normalIn, 8'hFF);
		sens.drive(8'h00, 300);
		scan();
		chk(catchFlag, 8'hF2);
		scan();
		chk(catchFlag, 8'h00);
		$display("test_groups done");
	endtask : test_groups
	task automatic test_every_scan();
		wr_reg(`CL_OFS_CTRL, 32'h0);
		sens.pulse(8'h01, 300);
		scan();
		chk(catchFlag, 8'h01);
		sens.pulse(8'h01, 300);
		chk(catchFlag, 8'h01);
		scan();
		chk(catchFlag, 8'h01);
		sens.drive(8'h04, 300);
		chk(normalIn, 8'h00);
		scan();
		chk(normalIn, 8'h04);
		$display("test_every_scan done");
	endtask : test_every_scan
	task automatic test_high_speed();
		wr_reg(`CL_OFS_CTRL, 32'h10);
		@(posedge mclk);
		#1 chk({linkEnable, ctrlDataEnable}, 2'b00);
		chk(progCapacity, `CL_CAP_HS);
		rd_chk(`CL_OFS_LIMITS, {`CL_RELAY_HS, `CL_CAP_HS});
		sens.drive(8'h00, 300);
		sens.drive(8'h04, 300);
		scan();
		chk(catchFlag, 8'h04);
		wr_reg(`CL_OFS_CTRL, 32'h0);
		@(posedge mclk);
		#1 chk({linkEnable, ctrlDataEnable}, 2'b11);
		chk(relayPoints, `CL_RELAY_STD);
		$display("test_high_speed done");
	endtask : test_high_speed
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : give_verdict
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 30000) begin
			error_cnt++;
			$display("[FAIL] t=%0t run did not finish", $time);
			give_verdict();
		end
	end
	initial begin
		repeat (5) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		#1 test_reset();
		test_short_pulse();
		test_groups();
		test_every_scan();
		test_high_speed();
		give_verdict();
	end
endmodule : scan_catch_input_latch_test
`default_nettype wire
